// ### hw/satc_pkg.sv
// package of constants and types for the secure alert tone control
package satc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ         = 200_000_000;
  localparam int TONE_HZ        = 750;
  localparam int BEEP_MS        = 87;
  // half period of the tone, rounded down
  localparam int TONE_HALF_CYC  = CLK_HZ / (2 * TONE_HZ);
  localparam int BEEP_CYC       = (CLK_HZ / 1000) * BEEP_MS;
  // loader sync clock divider half period, in cycles
  localparam int SYNC_HALF_CYC  = 100;

  // ****************************************
  // sizes and reset values
  // ****************************************
  localparam int NUM_MOD        = 8;
  localparam int NUM_PAIR       = 4;
  localparam logic [5:0] ALERT_EN_RST = 6'h3f;

  // alert enable bit positions
  localparam int AL_CLR_TX      = 0;
  localparam int AL_CLR_RX      = 1;
  localparam int AL_MISMATCH    = 2;
  localparam int AL_ERASE       = 3;
  localparam int AL_TX_LOSS     = 4;
  localparam int AL_RX_LOSS     = 5;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SATC_IDLE  = 2'b00,
    SATC_BEEP  = 2'b01,
    SATC_PULSE = 2'b10,
    SATC_CONT  = 2'b11
  } satc_state_t;

  // station activity inputs
  typedef struct packed {
    logic ptt;         // line or local push-to-talk
    logic ptt_coded;   // push-to-talk is encrypted
    logic rx_act;      // receive activity present
    logic rx_coded;    // receive activity is encrypted
    logic line_coded;  // wireline mode set to coded
    logic full_duplex; // full duplex or paired half duplex
  } satc_activity_t;

  // selection request from the station controller
  typedef struct packed {
    logic       valid;
    logic       erase;   // request is a key erase
    logic [2:0] digit;   // key digit minus one
  } satc_select_t;

endpackage

// ### hw/satc_top.sv
// secure alert tone control: module select, key watch, tones and erase
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// top module
// ****************************************
// Overview of operation
// - drive encrypt/decrypt control for up to eight modules
// - no module is ever set to encrypt and decrypt together
// - duplex modes put upper bank encrypt, lower bank decrypt
// - select from request line; front panel only in access-disable
// - every tone is 750 Hz, to line and speaker, never transmitter
// - six alert enables, all enabled after reset
// - one 87 ms beep at start of clear push-to-talk
// - one 87 ms beep at start of clear receive activity
// - mismatch beep at clear receive start while wireline is coded
// - continuous tone while key erase is asserted
// - 87 ms on/off while coded talk and selected key lost
// - watch key-ok line of each installed module while in encrypt or decrypt
// - 87 ms on/off while coded receive and decrypt key lost
// - loader attach forces access-disable until it is detached
// - make sync clock locked to the loader signal edges
// - active-low erase line clears all module keys at once
// - jumper-enabled active-high output grounds the erase line
// - erase requests on the request line are acted on
// - half duplex selects one of eight modules by digit 1 to 8
// - full duplex selects pair 1 to 4, upper encrypt lower decrypt
module satc_top
  import satc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // configuration
  input  wire logic [5:0]           alert_en_cfg,
  input  wire logic                 alert_cfg_load,
  input  wire logic                 erase_jumper,
  // station controller
  input  wire satc_activity_t       activity,
  input  wire satc_select_t         select_req,
  input  wire satc_select_t         panel_req,
  // pins from outside
  input  wire logic                 loader_attached,
  input  wire logic                 loader_sig,
  input  wire logic                 ext_key_reset_n,
  input  wire logic [NUM_MOD-1:0]   key_ok_line,
  input  wire logic [NUM_MOD-1:0]   mod_installed,
  // module control
  output logic [NUM_MOD-1:0]        mod_encrypt,
  output logic [NUM_MOD-1:0]        mod_decrypt,
  output logic                      erase_drive,
  output logic                      key_erase_n,
  // status
  output logic [2:0]                key_digit,
  output logic                      access_disable,
  output logic                      loader_sync_clk,
  output logic [NUM_MOD-1:0]        key_lost,
  // tone outputs
  output logic                      tone_line,
  output logic                      tone_speaker
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] ldr_att_sync_reg;
  logic [2:0] ldr_sig_sync_reg;
  logic [2:0] ext_rst_sync_reg;
  logic       ldr_att_reg;
  logic       ldr_sig_reg;
  logic       ext_rst_n_reg;
  logic [NUM_MOD-1:0] key_s1_reg;
  logic [NUM_MOD-1:0] key_s2_reg;
  logic [NUM_MOD-1:0] key_s3_reg;
  logic [NUM_MOD-1:0] key_ok_reg;

  // change is accepted once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[1] : cur;
  endfunction

  // three-stage capture of pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ldr_att_sync_reg <= 3'h0;
      ldr_sig_sync_reg <= 3'h0;
      ext_rst_sync_reg <= 3'h7;
      ldr_att_reg      <= 1'b0;
      ldr_sig_reg      <= 1'b0;
      ext_rst_n_reg    <= 1'b1;
      key_s1_reg       <= 8'hff;
      key_s2_reg       <= 8'hff;
      key_s3_reg       <= 8'hff;
      key_ok_reg       <= 8'hff;
    end else begin
      ldr_att_sync_reg <= {ldr_att_sync_reg[1:0], loader_attached};
      ldr_sig_sync_reg <= {ldr_sig_sync_reg[1:0], loader_sig};
      ext_rst_sync_reg <= {ext_rst_sync_reg[1:0], ext_key_reset_n};
      ldr_att_reg      <= filt(ldr_att_sync_reg, ldr_att_reg);
      ldr_sig_reg      <= filt(ldr_sig_sync_reg, ldr_sig_reg);
      ext_rst_n_reg    <= filt(ext_rst_sync_reg, ext_rst_n_reg);
      key_s1_reg       <= key_ok_line;
      key_s2_reg       <= key_s1_reg;
      key_s3_reg       <= key_s2_reg;
      for (int i = 0; i < NUM_MOD; i++) begin
        if (key_s2_reg[i] == key_s3_reg[i]) begin
          key_ok_reg[i] <= key_s2_reg[i];
        end
      end
    end
  end

  // ****************************************
  // configuration and access-disable
  // ****************************************
  logic [5:0] alert_en_reg;

  // alert enable store, all on after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alert_en_reg <= ALERT_EN_RST;
    end else if (alert_cfg_load) begin
      alert_en_reg <= alert_en_cfg;
    end
  end

  // loader presence holds access-disable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      access_disable <= 1'b0;
    end else begin
      access_disable <= ldr_att_reg;
    end
  end

  // ****************************************
  // module selection
  // ****************************************
  logic [2:0] sel_reg;
  logic       erase_req_reg;
  logic [NUM_MOD-1:0] enc_next;
  logic [NUM_MOD-1:0] dec_next;

  // request line always; panel only while access-disabled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_reg <= 3'h0;
    end else if (select_req.valid && !select_req.erase) begin
      sel_reg <= select_req.digit;
    end else if (panel_req.valid && !panel_req.erase && access_disable) begin
      sel_reg <= panel_req.digit;
    end
  end

  // mode decode: module i upper for i<4, lower for i>=4
  always_comb begin
    enc_next = '0;
    dec_next = '0;
    if (activity.full_duplex) begin
      // pair select, wraps digits above four onto the pairs
      enc_next[{1'b0, sel_reg[1:0]}] = 1'b1;
      dec_next[{1'b1, sel_reg[1:0]}] = 1'b1;
    end else if (activity.ptt) begin
      enc_next[sel_reg] = 1'b1;
    end else begin
      dec_next[sel_reg] = 1'b1;
    end
  end

  // module control lines, one mode each
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mod_encrypt <= 8'h00;
      mod_decrypt <= 8'h00;
      key_digit   <= 3'h0;
    end else begin
      mod_encrypt <= enc_next & mod_installed;
      mod_decrypt <= dec_next & mod_installed & ~enc_next;
      key_digit   <= sel_reg;
    end
  end

  // ****************************************
  // key erase
  // ****************************************
  // erase request from the line latches until reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      erase_req_reg <= 1'b0;
    end else if (select_req.valid && select_req.erase) begin
      erase_req_reg <= 1'b1;
    end
  end

  // erase outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      erase_drive <= 1'b0;
      key_erase_n <= 1'b1;
    end else begin
      erase_drive <= erase_req_reg & erase_jumper;
      key_erase_n <= ~(erase_req_reg & erase_jumper) & ext_rst_n_reg;
    end
  end

  // ****************************************
  // key watch
  // ****************************************
  logic enc_lost;
  logic dec_lost;

  // a low key-ok on an installed module in encrypt or decrypt marks the key lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      key_lost <= 8'h00;
    end else begin
      for (int i = 0; i < NUM_MOD; i++) begin
        if (!key_erase_n) begin
          key_lost[i] <= mod_installed[i];
        end else if (mod_installed[i] && !key_ok_reg[i] &&
                     (mod_encrypt[i] || mod_decrypt[i])) begin
          key_lost[i] <= 1'b1;
        end
      end
    end
  end

  assign enc_lost = |(key_lost & mod_encrypt);
  assign dec_lost = |(key_lost & mod_decrypt);

  // ****************************************
  // loader sync clock
  // ****************************************
  logic       ldr_sig_d_reg;
  logic [7:0] sync_cnt_reg;

  // divider restarted on each loader edge keeps phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ldr_sig_d_reg   <= 1'b0;
      sync_cnt_reg    <= 8'h00;
      loader_sync_clk <= 1'b0;
    end else begin
      ldr_sig_d_reg <= ldr_sig_reg;
      if (!access_disable) begin
        sync_cnt_reg    <= 8'h00;
        loader_sync_clk <= 1'b0;
      end else if (ldr_sig_reg != ldr_sig_d_reg) begin
        sync_cnt_reg    <= 8'h00;
        loader_sync_clk <= ldr_sig_reg;
      end else if (sync_cnt_reg == 8'(SYNC_HALF_CYC - 1)) begin
        sync_cnt_reg    <= 8'h00;
        loader_sync_clk <= ~loader_sync_clk;
      end else begin
        sync_cnt_reg <= sync_cnt_reg + 8'h01;
      end
    end
  end

  // ****************************************
  // alert sequencing
  // ****************************************
  logic        ptt_d_reg;
  logic        rx_d_reg;
  logic        beep_trig;
  logic        pulse_cond;
  logic        cont_cond;
  satc_state_t state_reg;
  logic [24:0] iv_cnt_reg;
  logic        pulse_on_reg;
  logic [17:0] tone_cnt_reg;
  logic        tone_sq_reg;
  logic        iv_end;

  // onset detection of talk and receive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptt_d_reg <= 1'b0;
      rx_d_reg  <= 1'b0;
    end else begin
      ptt_d_reg <= activity.ptt;
      rx_d_reg  <= activity.rx_act;
    end
  end

  assign beep_trig =
    (alert_en_reg[AL_CLR_TX] & activity.ptt & ~ptt_d_reg &
     ~activity.ptt_coded) |
    (alert_en_reg[AL_CLR_RX] & activity.rx_act & ~rx_d_reg &
     ~activity.rx_coded) |
    (alert_en_reg[AL_MISMATCH] & activity.rx_act & ~rx_d_reg &
     ~activity.rx_coded & activity.line_coded);
  assign pulse_cond =
    (alert_en_reg[AL_TX_LOSS] & activity.ptt & activity.ptt_coded &
     enc_lost) |
    (alert_en_reg[AL_RX_LOSS] & activity.rx_act & activity.rx_coded &
     dec_lost);
  assign cont_cond = alert_en_reg[AL_ERASE] & ~key_erase_n;
  assign iv_end    = (iv_cnt_reg == 25'(BEEP_CYC - 1));

  // tone pattern state, erase tone first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg    <= SATC_IDLE;
      iv_cnt_reg   <= 25'h0;
      pulse_on_reg <= 1'b0;
    end else begin
      case (state_reg)
        SATC_IDLE: begin
          iv_cnt_reg   <= 25'h0;
          pulse_on_reg <= 1'b1;
          if (cont_cond) begin
            state_reg <= SATC_CONT;
          end else if (pulse_cond) begin
            state_reg <= SATC_PULSE;
          end else if (beep_trig) begin
            state_reg <= SATC_BEEP;
          end
        end
        SATC_BEEP: begin
          iv_cnt_reg <= iv_cnt_reg + 25'h1;
          if (cont_cond) begin
            state_reg <= SATC_CONT;
          end else if (iv_end) begin
            state_reg <= SATC_IDLE;
          end
        end
        SATC_PULSE: begin
          if (cont_cond) begin
            state_reg <= SATC_CONT;
          end else if (!pulse_cond) begin
            state_reg <= SATC_IDLE;
          end else if (iv_end) begin
            iv_cnt_reg   <= 25'h0;
            pulse_on_reg <= ~pulse_on_reg;
          end else begin
            iv_cnt_reg <= iv_cnt_reg + 25'h1;
          end
        end
        SATC_CONT: begin
          if (!cont_cond) begin
            state_reg <= SATC_IDLE;
          end
        end
        default: state_reg <= SATC_IDLE;
      endcase
    end
  end

  // 750 Hz square wave from the system clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tone_cnt_reg <= 18'h0;
      tone_sq_reg  <= 1'b0;
    end else if (state_reg == SATC_IDLE) begin
      // restart while silent so every pattern started from idle opens on a high half
      tone_cnt_reg <= 18'h0;
      tone_sq_reg  <= 1'b1;
    end else if (tone_cnt_reg == 18'(TONE_HALF_CYC - 1)) begin
      tone_cnt_reg <= 18'h0;
      tone_sq_reg  <= ~tone_sq_reg;
    end else begin
      tone_cnt_reg <= tone_cnt_reg + 18'h1;
    end
  end

  // gated tone to line and speaker only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tone_line    <= 1'b0;
      tone_speaker <= 1'b0;
    end else begin
      tone_line <= tone_sq_reg & ((state_reg == SATC_BEEP) |
                   (state_reg == SATC_CONT) |
                   ((state_reg == SATC_PULSE) & pulse_on_reg));
      tone_speaker <= tone_sq_reg & ((state_reg == SATC_BEEP) |
                      (state_reg == SATC_CONT) |
                      ((state_reg == SATC_PULSE) & pulse_on_reg));
    end
  end

endmodule

`default_nettype wire

// ### tb/satc_mod_model.sv
// model of the plug-in encryption modules and the key loader pins
`timescale 1ns/1ps
`default_nettype none
module satc_mod_model #(
  parameter logic [7:0] BAD_KEY = 8'h01
) (
  // clock and station state
  input  wire logic       clk,
  input  wire logic       ptt,
  input  wire logic [7:0] mod_encrypt,
  // bench controls
  input  wire logic       loader_on,
  input  wire logic       ext_erase,
  // pins toward the board
  output logic [7:0]      key_ok_line,
  output logic            loader_attached,
  output logic            loader_sig,
  output logic            ext_key_reset_n
);
  logic [4:0] div_reg;
  // corrupt key pulls key-ok low during talk and encrypt
  assign key_ok_line = ~(BAD_KEY & mod_encrypt & {8{ptt}});
  // outside erase switch, active low
  assign ext_key_reset_n = ~ext_erase;
  assign loader_attached = loader_on;
  // loader signal toggles only while attached, rests low otherwise
  always_ff @(posedge clk) begin
    div_reg <= loader_on ? div_reg + 5'h01 : 5'h00;
    if (!loader_on)
      loader_sig <= 1'b0;
    else if (div_reg == 5'h1f)
      loader_sig <= ~loader_sig;
  end
endmodule
`default_nettype wire

// ### tb/satc_top_sva.sv
// port assertions for the secure alert tone control
`timescale 1ns/1ps
`default_nettype none
module satc_top_sva
  import satc_pkg::*;
(
  // clock and reset
  input wire logic           clk,
  input wire logic           rstn,
  // watched inputs
  input wire logic           erase_jumper,
  input wire satc_activity_t activity,
  input wire satc_select_t   select_req,
  input wire satc_select_t   panel_req,
  // watched outputs
  input wire logic [7:0]     mod_encrypt,
  input wire logic [7:0]     mod_decrypt,
  input wire logic           erase_drive,
  input wire logic           key_erase_n,
  input wire logic [2:0]     key_digit,
  input wire logic           access_disable,
  input wire logic           loader_sync_clk,
  input wire logic [7:0]     key_lost,
  input wire logic           tone_line,
  input wire logic           tone_speaker
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ****************************************
  // assertions
  // ****************************************
  a_no_dual_mode: assert property ((mod_encrypt & mod_decrypt) == 8'h00)
    else $error("module set to encrypt and decrypt");
  a_tone_both_ends: assert property (tone_line == tone_speaker)
    else $error("line and speaker tones differ");
  a_duplex_banks: assert property (activity.full_duplex [*4] |->
    mod_encrypt[7:4] == 4'h0 && mod_decrypt[3:0] == 4'h0)
    else $error("bank in wrong mode in full duplex");
  a_select_follows: assert property (select_req.valid && !select_req.erase
    && !panel_req.valid && !activity.full_duplex |->
    ##2 key_digit == $past(select_req.digit, 2))
    else $error("key digit does not follow request");
  a_panel_refused: assert property (!access_disable && panel_req.valid
    && !select_req.valid |-> ##2 $stable(key_digit))
    else $error("panel request taken outside access disable");
  a_line_erase: assert property (select_req.valid && select_req.erase
    && erase_jumper |-> ##2 erase_drive && !key_erase_n)
    else $error("line erase request not acted on");
  a_erase_grounds: assert property (erase_drive |-> !key_erase_n)
    else $error("erase drive high but erase line high");
  a_erase_held: assert property (erase_drive |=> erase_drive)
    else $error("erase drive released before reset");
  a_sync_idle: assert property (!access_disable && !$past(access_disable)
    |-> !loader_sync_clk)
    else $error("sync clock runs outside access disable");
  a_lost_sticky: assert property
    ((key_lost & $past(key_lost)) == $past(key_lost))
    else $error("key lost flag cleared");

  // ****************************************
  // covers
  // ****************************************
  c_select: cover property (select_req.valid ##2 mod_decrypt != 8'h00);
  c_erase: cover property (erase_drive && tone_line);
  c_panel: cover property (access_disable && panel_req.valid);
endmodule

bind satc_top satc_top_sva sva_u (.clk, .rstn, .erase_jumper, .activity,
  .select_req, .panel_req, .mod_encrypt, .mod_decrypt, .erase_drive,
  .key_erase_n, .key_digit, .access_disable, .loader_sync_clk, .key_lost,
  .tone_line, .tone_speaker);
`default_nettype wire

// ### tb/satc_top_tb_top.sv
// self-checking bench for the secure alert tone control
`timescale 1ns/1ps
`default_nettype none
module satc_top_tb_top;
  import satc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] alert_en_cfg = 6'h3f;
  logic alert_cfg_load = 1'b0;
  logic erase_jumper = 1'b0;
  satc_activity_t activity = '0;
  satc_select_t select_req = '0;
  satc_select_t panel_req = '0;
  logic loader_on = 1'b0;
  logic ext_erase = 1'b0;
  logic [7:0] mod_installed = 8'hff;
  wire logic loader_attached, loader_sig, ext_key_reset_n;
  wire logic [7:0] key_ok_line, mod_encrypt, mod_decrypt, key_lost;
  wire logic erase_drive, key_erase_n, access_disable, loader_sync_clk;
  wire logic tone_line, tone_speaker;
  wire logic [2:0] key_digit;
  int n_mismatch = 0;
  int n_checks = 0;
  int i;
  logic [31:0] seed = 32'ha002;
  logic hit;
  logic [2:0] d;

  always #2.5 clk = ~clk;

  satc_top dut_u (.clk, .rstn, .alert_en_cfg, .alert_cfg_load,
    .erase_jumper, .activity, .select_req, .panel_req, .loader_attached,
    .loader_sig, .ext_key_reset_n, .key_ok_line, .mod_installed,
    .mod_encrypt, .mod_decrypt, .erase_drive, .key_erase_n, .key_digit,
    .access_disable, .loader_sync_clk, .key_lost, .tone_line,
    .tone_speaker);
  satc_mod_model part_u (.clk, .ptt(activity.ptt), .mod_encrypt,
    .loader_on, .ext_erase, .key_ok_line, .loader_attached, .loader_sig,
    .ext_key_reset_n);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for one of several conditions
  task automatic wait_for(input int sel, input int n, output logic h);
    logic s0;
    s0 = loader_sync_clk;
    h = 1'b0;
    repeat (n) begin
      @(negedge clk);
      case (sel)
        0: h = h | (tone_line === 1'b1);
        1: h = h | (access_disable === 1'b1);
        2: h = h | (key_erase_n === 1'b0);
        3: h = h | (loader_sync_clk !== s0);
        default: h = h | (access_disable === 1'b0);
      endcase
    end
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    cyc(10);
    rstn = 1'b1;
  endtask
  task automatic req(input logic pnl, input logic er, input logic [2:0] q);
    if (pnl) panel_req = '{1'b1, er, q};
    else select_req = '{1'b1, er, q};
    cyc(1);
    panel_req = '0;
    select_req = '0;
    cyc(2);
  endtask
  task automatic tone_case(input logic [5:0] en, input logic [5:0] act,
                           input logic [7:0] exp);
    do_reset();
    alert_en_cfg = en;
    alert_cfg_load = 1'b1;
    cyc(1);
    alert_cfg_load = 1'b0;
    activity = satc_activity_t'(act);
    wait_for(0, 40, hit);
    chk({7'h0, hit}, exp);
    activity = '0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    do_reset();
    cyc(1);
    chk({7'h0, key_erase_n}, 8'h01);
    chk(mod_encrypt | key_lost, 8'h00);
    // half duplex random digits, both ends first
    for (i = 0; i < 10; i++) begin
      d = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'(rnd() >> 29);
      req(1'b0, 1'b0, d);
      chk({5'h0, key_digit}, {5'h0, d});
      chk(mod_decrypt, 8'h01 << d);
    end
    $display("test half duplex done");
    activity.full_duplex = 1'b1;
    for (i = 0; i < 4; i++) begin
      req(1'b0, 1'b0, i[2:0]);
      chk(mod_encrypt, 8'h01 << i);
      chk(mod_decrypt, 8'h10 << i);
    end
    activity.full_duplex = 1'b0;
    $display("test full duplex done");
    req(1'b1, 1'b0, 3'h5);
    chk({5'h0, key_digit}, 8'h03);
    loader_on = 1'b1;
    wait_for(1, 20, hit);
    chk({7'h0, hit}, 8'h01);
    req(1'b1, 1'b0, 3'h5);
    chk({5'h0, key_digit}, 8'h05);
    wait_for(3, 300, hit);
    chk({7'h0, hit}, 8'h01);
    loader_on = 1'b0;
    wait_for(4, 20, hit);
    chk({7'h0, hit}, 8'h01);
    $display("test loader done");
    tone_case(6'h3f, 6'h20, 8'h01);
    tone_case(6'h00, 6'h20, 8'h00);
    tone_case(6'h02, 6'h08, 8'h01);
    tone_case(6'h01, 6'h08, 8'h00);
    tone_case(6'h04, 6'h0a, 8'h01);
    tone_case(6'h04, 6'h08, 8'h00);
    tone_case(6'h10, 6'h30, 8'h01);
    chk(key_lost, 8'h01);
    $display("test tones done");
    do_reset();
    erase_jumper = 1'b1;
    req(1'b0, 1'b1, 3'h0);
    chk({6'h0, erase_drive, key_erase_n}, 8'h02);
    cyc(8);
    chk(key_lost, mod_installed);
    wait_for(0, 20, hit);
    chk({7'h0, hit}, 8'h01);
    do_reset();
    erase_jumper = 1'b0;
    ext_erase = 1'b1;
    wait_for(2, 15, hit);
    chk({7'h0, hit}, 8'h01);
    chk({7'h0, erase_drive}, 8'h00);
    // keys stay lost after the outside erase is let go
    ext_erase = 1'b0;
    cyc(10);
    alert_en_cfg = 6'h20;
    alert_cfg_load = 1'b1;
    cyc(1);
    alert_cfg_load = 1'b0;
    activity = satc_activity_t'(6'h0c);
    wait_for(0, 40, hit);
    chk({7'h0, hit}, 8'h01);
    activity = '0;
    $display("test erase done");
    print_verdict();
  end

  // watchdog well past the expected nine hundred or so cycles
  initial begin
    #250000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
